// ==== src/drive_psm_pkg.sv ====
/*
 Package for the drive power state machine: register offsets, field
 positions, reset values, option codes, state encodings and carrier types.
 Assumes a single APB clock domain; every offset is an index, shifted left by two for the byte address.
*/
package drive_psm_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [15:0] IDX_COMMAND = 16'h6040;
    localparam logic [15:0] IDX_STATE = 16'h6041;
    localparam logic [15:0] IDX_QS_REACTION = 16'h605a;
    localparam logic [15:0] IDX_SD_REACTION = 16'h605b;
    localparam logic [15:0] IDX_MODE_REQ = 16'h6060;
    localparam logic [15:0] IDX_MODE_EFF = 16'h6061;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'h7000;
    localparam logic [15:0] IDX_IRQ_MASK = 16'h7001;

    // Command word bit positions
    localparam int CMD_SWITCH_ON = 0;
    localparam int CMD_ENABLE_VOLT = 1;
    localparam int CMD_QUICK_STOP_N = 2;
    localparam int CMD_ENABLE_OP = 3;
    localparam int CMD_FAULT_RESET = 7;

    // Reset values
    localparam logic [15:0] COMMAND_RESET = 16'h0000;
    localparam logic [15:0] QS_REACTION_RESET = 16'h0002;
    localparam logic [15:0] SD_REACTION_RESET = 16'h0001;
    localparam logic [7:0] MODE_RESET = 8'h00;

    // Reaction option codes
    localparam logic [15:0] OPT_COAST = 16'h0000;
    localparam logic [15:0] OPT_SLOW_RAMP = 16'h0001;
    localparam logic [15:0] OPT_QS_RAMP = 16'h0002;
    localparam logic [15:0] OPT_SLOW_HOLD = 16'h0005;
    localparam logic [15:0] OPT_QS_HOLD = 16'h0006;

    // Ramp and self-test lengths in clock cycles
    localparam int SLOW_RAMP_CYCLES = 64;
    localparam int QS_RAMP_CYCLES = 16;
    localparam int SELFTEST_CYCLES = 8;

    // Interrupt status bits
    localparam int IRQ_STATE_CHANGE = 0;
    localparam int IRQ_FATAL = 1;
    localparam int IRQ_LIMIT = 2;
    localparam int IRQ_WIDTH = 3;

    // State word encodings, bits 6,5,3,2,1,0 significant
    localparam logic [15:0] SW_NOT_READY = 16'h0000;
    localparam logic [15:0] SW_DISABLED = 16'h0040;
    localparam logic [15:0] SW_READY = 16'h0021;
    localparam logic [15:0] SW_SWITCHED_ON = 16'h0023;
    localparam logic [15:0] SW_OP_ENABLED = 16'h0027;
    localparam logic [15:0] SW_QUICK_STOP = 16'h0007;
    localparam logic [15:0] SW_FAULT_REACT = 16'h000f;
    localparam logic [15:0] SW_FAULT = 16'h0008;

    typedef enum logic [3:0] {
        ST_SELFTEST = 4'h0,
        ST_NOT_READY = 4'h1,
        ST_DISABLED = 4'h2,
        ST_READY = 4'h3,
        ST_SWITCHED_ON = 4'h4,
        ST_OP_ENABLED = 4'h5,
        ST_QUICK_STOP = 4'h6,
        ST_FAULT_REACT = 4'h7,
        ST_FAULT = 4'h8
    } power_state_t;

    // Drive-stage outputs grouped for the motor control side
    typedef struct packed {
        logic energized;
        logic braking;
        logic quick_ramp;
    } stage_ctrl_t;

endpackage

// ==== src/drive_power_state_machine.sv ====
/*
 Power state machine of a motor drive with an APB register slave.
 Assumes the limit switch, fault and fatal inputs are asynchronous pins,
 and that ramp completion is modelled by a fixed cycle count.
*/
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
module drive_power_state_machine
    import drive_psm_pkg::*;
(
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive pins
    input wire logic limit_switch,
    input wire logic fault_event,
    input wire logic fatal_error,
    // Drive stage and interrupt
    output stage_ctrl_t stage,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
        end else begin
            sync1 <= {fatal_error, fault_event, limit_switch};
            sync2 <= sync1;
        end
    end

    wire limit_s = sync2[0];
    wire fault_s = sync2[1];
    wire fatal_s = sync2[2];

    ////////////////////////////////////////////////////////////////////
    // Register access decode
    function automatic logic hit(input logic [31:0] addr, input logic [15:0] idx);
        hit = (addr == {14'h0, idx, 2'b00});
    endfunction

    logic [15:0] command;
    logic [15:0] qs_reaction;
    logic [15:0] sd_reaction;
    logic [7:0] mode_req;
    logic [7:0] mode_eff;
    logic [IRQ_WIDTH-1:0] irq_status;
    logic [IRQ_WIDTH-1:0] irq_mask;
    logic [15:0] state_word;

    wire access = psel && penable;
    wire wr = access && pwrite;
    wire hit_cmd = hit(paddr, IDX_COMMAND);
    wire hit_st = hit(paddr, IDX_STATE);
    wire hit_qs = hit(paddr, IDX_QS_REACTION);
    wire hit_sd = hit(paddr, IDX_SD_REACTION);
    wire hit_mr = hit(paddr, IDX_MODE_REQ);
    wire hit_me = hit(paddr, IDX_MODE_EFF);
    wire hit_is = hit(paddr, IDX_IRQ_STATUS);
    wire hit_im = hit(paddr, IDX_IRQ_MASK);
    wire mapped = hit_cmd | hit_st | hit_qs | hit_sd | hit_mr | hit_me | hit_is | hit_im;
    // Reserved reaction codes and writes to read-only words are refused
    wire qs_code_ok = (pwdata[15:0] == OPT_COAST) || (pwdata[15:0] == OPT_SLOW_RAMP)
        || (pwdata[15:0] == OPT_QS_RAMP) || (pwdata[15:0] == OPT_SLOW_HOLD)
        || (pwdata[15:0] == OPT_QS_HOLD);
    wire sd_code_ok = (pwdata[15:0] == OPT_COAST) || (pwdata[15:0] == OPT_SLOW_RAMP);
    wire bad_write = pwrite && ((hit_qs && !qs_code_ok) || (hit_sd && !sd_code_ok)
        || hit_st || hit_me);
    wire err = !mapped || bad_write;

    assign pready = 1'b1;
    assign pslverr = access && err;

    wire [31:0] read_mux =
        hit_cmd ? {16'h0000, command} :
        hit_st ? {16'h0000, state_word} :
        hit_qs ? {16'h0000, qs_reaction} :
        hit_sd ? {16'h0000, sd_reaction} :
        hit_mr ? {24'h000000, mode_req} :
        hit_me ? {24'h000000, mode_eff} :
        hit_is ? {29'h0, irq_status} :
        hit_im ? {29'h0, irq_mask} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= read_mux;
        end
    end

    wire cmd_write = wr && !err && hit_cmd;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            command <= COMMAND_RESET;
            qs_reaction <= QS_REACTION_RESET;
            sd_reaction <= SD_REACTION_RESET;
            mode_req <= MODE_RESET;
            irq_mask <= '0;
        end else if (wr && !err) begin
            if (hit_cmd) command <= pwdata[15:0];
            if (hit_qs) qs_reaction <= pwdata[15:0];
            if (hit_sd) sd_reaction <= pwdata[15:0];
            if (hit_mr) mode_req <= pwdata[7:0];
            if (hit_im) irq_mask <= pwdata[IRQ_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Command decode on bits 7,3,2,1,0 with don't-care bits ignored
    wire [4:0] cbits = {command[CMD_FAULT_RESET], command[CMD_ENABLE_OP],
        command[CMD_QUICK_STOP_N], command[CMD_ENABLE_VOLT], command[CMD_SWITCH_ON]};
    wire c_shutdown = (cbits[4] == 1'b0) && (cbits[2:0] == 3'b110);
    wire c_switch_on = (cbits == 5'b00111);
    wire c_enable_op = (cbits == 5'b01111);
    wire c_disable_v = (cbits[4] == 1'b0) && (cbits[1] == 1'b0);
    wire c_quick_stop = (cbits[4] == 1'b0) && (cbits[2:1] == 2'b01);

    // Edge detection of fault reset and enable operation bits
    logic prev_reset_bit;
    logic prev_enop_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reset_bit <= 1'b0;
            prev_enop_bit <= 1'b0;
        end else begin
            prev_reset_bit <= command[CMD_FAULT_RESET];
            prev_enop_bit <= command[CMD_ENABLE_OP];
        end
    end
    wire reset_rise = command[CMD_FAULT_RESET] && !prev_reset_bit;
    wire enop_rise = command[CMD_ENABLE_OP] && !prev_enop_bit
        && (cbits[4] == 1'b0) && (cbits[1:0] == 2'b11);

    ////////////////////////////////////////////////////////////////////
    // State machine with halt reactions
    power_state_t state;
    power_state_t next_state;
    logic [7:0] ramp;
    logic [7:0] next_ramp;
    logic ramping;
    logic next_ramping;
    logic quick;
    logic next_quick;
    logic limit_prev;

    wire ramp_done = ramping && (ramp == 8'h00);
    wire limit_rise = limit_s && !limit_prev;
    wire [15:0] qs_opt = qs_reaction;
    wire qs_hold = (qs_opt == OPT_SLOW_HOLD) || (qs_opt == OPT_QS_HOLD);
    wire qs_fast = (qs_opt == OPT_QS_RAMP) || (qs_opt == OPT_QS_HOLD);

    always_comb begin
        next_state = state;
        next_ramp = (ramping && ramp != 8'h00) ? ramp - 8'h01 : ramp;
        next_ramping = ramping && (ramp != 8'h00);
        next_quick = quick;
        if (fatal_s && state != ST_SELFTEST) begin
            next_state = ST_NOT_READY;
            next_ramping = 1'b0;
        end else if (fault_s && state != ST_SELFTEST && state != ST_NOT_READY
                && state != ST_FAULT && state != ST_FAULT_REACT) begin
            next_state = ST_FAULT_REACT;
            next_ramping = 1'b0;
        end else begin
            case (state)
                ST_SELFTEST: begin
                    if (ramp == 8'h00) next_state = ST_DISABLED;
                end
                ST_NOT_READY: next_state = ST_NOT_READY;
                ST_DISABLED: begin
                    if (c_shutdown) next_state = ST_READY;
                end
                ST_READY: begin
                    if (c_disable_v) next_state = ST_DISABLED;
                    else if (c_quick_stop) next_state = ST_DISABLED;
                    else if (c_switch_on) next_state = ST_SWITCHED_ON;
                end
                ST_SWITCHED_ON: begin
                    if (c_disable_v || c_quick_stop) next_state = ST_DISABLED;
                    else if (c_shutdown) next_state = ST_READY;
                    else if (c_enable_op) next_state = ST_OP_ENABLED;
                end
                ST_OP_ENABLED: begin
                    if (c_disable_v) begin
                        next_state = ST_DISABLED;
                    end else if (c_quick_stop || limit_rise) begin
                        // Quick stop reaction
                        next_state = ST_QUICK_STOP;
                        next_quick = 1'b1;
                        next_ramping = (qs_opt != OPT_COAST);
                        next_ramp = qs_fast ? 8'(QS_RAMP_CYCLES) : 8'(SLOW_RAMP_CYCLES);
                    end else if (c_shutdown) begin
                        // Shutdown reaction
                        next_state = ST_READY;
                        next_quick = 1'b0;
                        next_ramping = (sd_reaction == OPT_SLOW_RAMP);
                        next_ramp = 8'(SLOW_RAMP_CYCLES);
                    end else if (c_switch_on) begin
                        next_state = ST_SWITCHED_ON;
                    end
                end
                ST_QUICK_STOP: begin
                    if (c_disable_v) begin
                        next_state = ST_DISABLED;
                        next_ramping = 1'b0;
                    end else if (!ramping && !qs_hold) begin
                        next_state = ST_DISABLED;
                    end else if (ramp_done && !qs_hold) begin
                        next_state = ST_DISABLED;
                    end else if (!ramping && qs_hold && enop_rise) begin
                        next_state = ST_OP_ENABLED;
                    end
                end
                ST_FAULT_REACT: next_state = ST_FAULT;
                ST_FAULT: begin
                    if (reset_rise) next_state = ST_DISABLED;
                end
                default: next_state = ST_NOT_READY;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_SELFTEST;
            ramp <= 8'(SELFTEST_CYCLES);
            ramping <= 1'b0;
            quick <= 1'b0;
            limit_prev <= 1'b0;
        end else begin
            state <= next_state;
            ramp <= (state == ST_SELFTEST && ramp != 8'h00) ? ramp - 8'h01 : next_ramp;
            ramping <= next_ramping;
            quick <= next_quick;
            limit_prev <= limit_s;
        end
    end

    // Mode takes effect one clock after the request register; mode-specific loops sit outside this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_eff <= MODE_RESET;
        end else begin
            mode_eff <= mode_req;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // State word and drive stage
    function automatic logic [15:0] encode(input power_state_t s);
        case (s)
            ST_DISABLED: encode = SW_DISABLED;
            ST_READY: encode = SW_READY;
            ST_SWITCHED_ON: encode = SW_SWITCHED_ON;
            ST_OP_ENABLED: encode = SW_OP_ENABLED;
            ST_QUICK_STOP: encode = SW_QUICK_STOP;
            ST_FAULT_REACT: encode = SW_FAULT_REACT;
            ST_FAULT: encode = SW_FAULT;
            default: encode = SW_NOT_READY;
        endcase
    endfunction

    assign state_word = encode(state);

    // Ramps keep the stage energised until braking is done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage <= '0;
        end else begin
            stage.energized <= (next_state == ST_OP_ENABLED) || next_ramping
                || (next_state == ST_QUICK_STOP && qs_hold);
            stage.braking <= next_ramping;
            stage.quick_ramp <= next_ramping && next_quick && qs_fast;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Interrupts: set wins over write-one-to-clear
    wire [IRQ_WIDTH-1:0] irq_set = {limit_rise, fatal_s && state != ST_NOT_READY,
        next_state != state};
    wire [IRQ_WIDTH-1:0] irq_clr = (wr && !err && hit_is) ? pwdata[IRQ_WIDTH-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////
    // Assertions
    AST_NOT_READY_STICKS: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_NOT_READY |=> state == ST_NOT_READY)
        else $error("left not-ready state");
    AST_SELFTEST_EXIT: assert property (@(posedge pclk) disable iff (!presetn)
        $past(state) == ST_SELFTEST && state != ST_SELFTEST && !$past(fatal_s)
        |-> state == ST_DISABLED)
        else $error("self-test did not end in switch-on-disabled");
    AST_SHUTDOWN_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_DISABLED && c_shutdown && !fatal_s && !fault_s
        |=> state == ST_READY)
        else $error("shutdown not decoded");
    AST_ENABLE_OP: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_SWITCHED_ON && cbits == 5'b01111 && !fatal_s && !fault_s
        |=> state == ST_OP_ENABLED)
        else $error("enable operation not decoded");
    AST_DISABLE_VOLT: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_READY && cbits[4] == 1'b0 && cbits[1] == 1'b0 && !fatal_s && !fault_s
        |=> state == ST_DISABLED)
        else $error("disable voltage not decoded");
    AST_FAULT_EDGE: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_FAULT && !reset_rise && !fatal_s |=> state == ST_FAULT)
        else $error("fault left without rising reset edge");
    AST_STATE_WORD: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_OP_ENABLED |-> (state_word & 16'h006f) == SW_OP_ENABLED)
        else $error("state word encoding wrong");
    AST_QS_COAST: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_OP_ENABLED && c_quick_stop && !c_disable_v && qs_opt == OPT_COAST
        && !fatal_s && !fault_s |=> !stage.energized ##1 state == ST_DISABLED)
        else $error("quick stop code 0 did not coast");
    AST_QS_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state == ST_QUICK_STOP && qs_hold && !c_disable_v && !enop_rise && !fatal_s
        && !fault_s |=> state == ST_QUICK_STOP)
        else $error("quick stop hold not kept");
    AST_MODE_EFFECT: assert property (@(posedge pclk) disable iff (!presetn)
        wr && !err && hit_mr |-> ##2 mode_eff == $past(pwdata[7:0], 2))
        else $error("mode request not taken over");
    AST_COMMAND_TAKEN: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_write |=> command == $past(pwdata[15:0]))
        else $error("command word write not taken");
    AST_STATE_CHANGE_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        state != $past(state) |-> irq_status[IRQ_STATE_CHANGE])
        else $error("state change flag not set");

    COV_REACH_OP: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_SWITCHED_ON ##1 state == ST_OP_ENABLED);
    COV_QS_RETURN: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_QUICK_STOP ##1 state == ST_OP_ENABLED);
    COV_FAULT_RESET: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_FAULT ##1 state == ST_DISABLED);
    COV_FATAL: cover property (@(posedge pclk) disable iff (!presetn)
        state == ST_NOT_READY);

endmodule

// ==== verification/fieldbus_master.sv ====
/*
 Fieldbus master model: issues APB transfers to the drive register slave.
 Assumes one clock; each call waits for pready, with no fixed latency.
*/
`timescale 1ns/1ps
module fieldbus_master (
    // Clock and answer
    input wire logic pclk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [31:0] paddr,
    output logic [31:0] pwdata,
    // Result seen by the bench
    output logic rd_done,
    output logic [31:0] rd_val,
    output logic slverr
);
    initial begin
        {psel, penable, pwrite, paddr, pwdata, rd_done, rd_val, slverr} = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    // State changes are requested by command word writes and by the limit, fault and fatal pins
    task automatic xfer(input logic [15:0] idx, input logic wr, input logic [31:0] d,
                        input logic note);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {14'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_val <= prdata;
        slverr <= pslverr;
        rd_done <= note;
        psel <= 1'b0;
        penable <= 1'b0;
        // Idle edge so the strobe below is never set twice in one step
        @(posedge pclk);
        rd_done <= 1'b0;
    endtask
endmodule

// ==== verification/tb_drive_power_state_machine.sv ====
/*
 Self-checking bench for the drive power state machine.
 Assumes the fieldbus master model and the package constants for ramps.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end
module tb_drive_power_state_machine;
    import drive_psm_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rd_done, slverr;
    logic limit_switch, fault_event, fatal_error;
    logic [31:0] paddr, pwdata, prdata, rd_val;
    stage_ctrl_t stage;
    logic [31:0] q[$];
    int err_count = 0, n_tests = 0, cyc = 0;
    integer seed = 32'h3efe;
    logic [7:0] mode;
    logic [31:0] exp_val;

    drive_power_state_machine dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .limit_switch(limit_switch),
        .fault_event(fault_event), .fatal_error(fatal_error), .stage(stage), .irq(irq));
    fieldbus_master m (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .rd_done(rd_done), .rd_val(rd_val), .slverr(slverr));

    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    task automatic final_report();
        $display("Mismatches %0d of %0d comparisons", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, well above the longest expected run
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            final_report();
        end
    end

    // Compares each noted expectation against the next result read back
    always @(posedge pclk) begin
        if (rd_done === 1'b1) begin
            // Pop once: the macro names its expected value twice
            exp_val = q.pop_front();
            `CHK(rd_val, exp_val)
        end
    end

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        m.xfer(idx, 1'b1, d, 1'b0);
    endtask
    task automatic chk_reg(input logic [15:0] idx, input logic [31:0] e);
        q.push_back(e);
        m.xfer(idx, 1'b0, 32'h0, 1'b1);
    endtask
    // Polls the state word under a bound, then notes the final compare
    task automatic wait_state(input logic [15:0] e, input int n);
        for (int i = 0; i < n; i++) begin
            m.xfer(IDX_STATE, 1'b0, 32'h0, 1'b0);
            if (m.rd_val[15:0] === e) break;
        end
        chk_reg(IDX_STATE, {16'h0, e});
    endtask
    task automatic cmd(input logic [15:0] c, input logic [15:0] e);
        wr(IDX_COMMAND, {16'h0, c});
        wait_state(e, 60);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, limit_switch, fault_event, fatal_error} = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wait_state(SW_DISABLED, 20);
        chk_reg(IDX_QS_REACTION, 32'h2);
        chk_reg(IDX_SD_REACTION, 32'h1);
        wr(IDX_IRQ_MASK, 32'h7);
        wr(IDX_COMMAND, 32'h0f);
        repeat (4) @(posedge pclk);
        chk_reg(IDX_STATE, {16'h0, SW_DISABLED});
        cmd(16'h0e, SW_READY);
        cmd(16'h07, SW_SWITCHED_ON);
        cmd(16'h0f, SW_OP_ENABLED);
        `CHK(irq, 1'b1)
        wr(IDX_IRQ_STATUS, 32'h7);
        `CHK(irq, 1'b0)
        wr(IDX_SD_REACTION, 32'h2);
        `CHK(slverr, 1'b1)
        wr(IDX_STATE, 32'h0);
        `CHK(slverr, 1'b1)
        wr(16'h0100, 32'h0);
        `CHK(slverr, 1'b1)
        cmd(16'h06, SW_READY);
        cmd(16'h07, SW_SWITCHED_ON);
        cmd(16'h0f, SW_OP_ENABLED);
        wr(IDX_QS_REACTION, 32'h6);
        cmd(16'h0b, SW_QUICK_STOP);
        repeat (QS_RAMP_CYCLES + 10) @(posedge pclk);
        chk_reg(IDX_STATE, {16'h0, SW_QUICK_STOP});
        `CHK(stage.energized, 1'b1)
        wr(IDX_COMMAND, 32'h03);
        cmd(16'h0f, SW_OP_ENABLED);
        wr(IDX_QS_REACTION, 32'h0);
        cmd(16'h02, SW_DISABLED);
        `CHK(stage, 3'b000)
        wr(IDX_QS_REACTION, 32'h1);
        cmd(16'h06, SW_READY);
        cmd(16'h07, SW_SWITCHED_ON);
        cmd(16'h0f, SW_OP_ENABLED);
        cmd(16'h0b, SW_QUICK_STOP);
        `CHK(stage.braking, 1'b1)
        wait_state(SW_DISABLED, 30);
        mode = 8'($random(seed));
        wr(IDX_MODE_REQ, {24'h0, mode});
        chk_reg(IDX_MODE_EFF, {24'h0, mode});
        cmd(16'h06, SW_READY);
        cmd(16'h07, SW_SWITCHED_ON);
        cmd(16'h0f, SW_OP_ENABLED);
        wr(IDX_QS_REACTION, 32'h6);
        limit_switch <= 1'b1;
        wait_state(SW_QUICK_STOP, 40);
        limit_switch <= 1'b0;
        cmd(16'h00, SW_DISABLED);
        fault_event <= 1'b1;
        wait_state(SW_FAULT, 20);
        fault_event <= 1'b0;
        wr(IDX_COMMAND, 32'h00);
        cmd(16'h80, SW_DISABLED);
        fatal_error <= 1'b1;
        wait_state(SW_NOT_READY, 20);
        wr(IDX_COMMAND, 32'h06);
        repeat (8) @(posedge pclk);
        chk_reg(IDX_STATE, {16'h0, SW_NOT_READY});
        repeat (4) @(posedge pclk);
        final_report();
    end
endmodule
